// ==== inc/omc_pkg.sv ====
package omc_pkg;
  // byte offsets inside the 1024-byte window, relative to the module base
  localparam logic [9:0] MODULE_BASE = 10'h000;
  localparam logic [9:0] OFS_PRISM = 10'h000;
  localparam logic [9:0] OFS_DATA1 = 10'h002;
  localparam logic [9:0] OFS_DATA2 = 10'h004;
  localparam logic [9:0] OFS_DATA3 = 10'h006;
  localparam logic [9:0] OFS_DATA4 = 10'h008;
  localparam logic [9:0] OFS_RB_FIRST = 10'h00a;
  localparam logic [9:0] OFS_RB_LAST = 10'h00c;
  localparam logic [9:0] OFS_CTRL = 10'h100;
  localparam logic [9:0] OFS_STAT = 10'h104;
  localparam logic [9:0] OFS_CMD = 10'h106;
  localparam logic [9:0] OFS_ADDR = 10'h108;
  // window areas selected by address bits 9:8
  localparam logic [1:0] AREA_DATA = 2'h0;
  localparam logic [1:0] AREA_CTRL = 2'h1;
  // sizes and field positions
  localparam int N_MOD = 4;
  localparam int PRISM_BITS = 12;
  localparam int CHAN_BITS = 5;
  localparam logic [3:0] PRISM_UNUSED = 4'hf;
  localparam logic [6:0] DEFAULT_ADDR = 7'h49;
  localparam logic [15:0] CTRL_MASK = 16'hf3f8;
  localparam int CTRL_POL_BIT = 9;
  localparam int CTRL_RST_LSB = 12;
  localparam int CMD_R_LSB = 12;
  localparam int CMD_W_LSB = 8;
  localparam logic [3:0] CNT_MAX = 4'h8;
  localparam logic [15:0] READ_UNMAPPED = 16'hffff;
  // hardware revision code: arbitrary value
  localparam logic [2:0] HW_REV = 3'h0;
  // serial bit timing on the link clock
  localparam int LINK_PERIOD_NS = 125;
  localparam int I2C_BIT_NS = 10000;
  localparam logic [4:0] QTR_CYC = 5'(I2C_BIT_NS / (4 * LINK_PERIOD_NS));
  // one attenuator transaction as handed to the link domain
  typedef struct packed {
    logic [1:0] mod;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [3:0] wcnt;
    logic [3:0] rcnt;
    logic [15:0] data;
  } omc_req_t;
  // result handed back to the register domain
  typedef struct packed {
    logic [31:0] rx;
    logic nack;
  } omc_res_t;
  // link sequencer states
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_START = 3'b001,
    L_BIT = 3'b010,
    L_STOP = 3'b011,
    L_DONE = 3'b100
  } omc_lstate_t;
endpackage

// ==== hw/omc_port_ctrl.sv ====
`timescale 1ns/1ps
module omc_port_ctrl
  import omc_pkg::*;
(
  // system clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // register port
  input wire logic [9:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // module fit and error pins
  input wire logic [N_MOD-1:0] MOD_ATTEN_I,
  input wire logic [N_MOD-1:0] MOD_ERR_I,
  // prism switch drivers
  output logic [PRISM_BITS-1:0] PRISM_CLOSE_O,
  // multi-switch parallel ports
  output logic [N_MOD-1:0][CHAN_BITS-1:0] CHAN_SEL_O,
  output logic [N_MOD-1:0] CHAN_RESET_O,
  // attenuator serial buses, link clock domain
  input wire logic LINK_CLK_I,
  output logic [N_MOD-1:0] SCL_O,
  output logic [N_MOD-1:0] SCL_OE_O,
  input wire logic [N_MOD-1:0] SDA_I,
  output logic [N_MOD-1:0] SDA_O,
  output logic [N_MOD-1:0] SDA_OE_O
);

  // ---------------- register domain ----------------
  logic [PRISM_BITS-1:0] prism; // path states
  logic [N_MOD-1:0][15:0] mod_data; // per-module data words
  logic [15:0] ctrl; // control register
  logic [15:0] cmd_reg; // command register
  logic [6:0] tgt_addr; // target module address
  logic [31:0] readback; // shared read-back bytes
  logic [N_MOD-1:0] comm_err; // sticky link error per module
  logic busy; // a transaction is in flight
  omc_req_t req; // held stable while busy
  logic req_tgl; // toggles once per launch
  logic [N_MOD-1:0] atten_s1, atten_s2; // mode pin synchroniser
  logic [N_MOD-1:0] err_s1, err_s2; // error pin synchroniser
  logic done_s1, done_s2, done_s3; // done toggle synchroniser
  logic done_ev;
  logic [1:0] wr_mod; // module index of a data write
  logic wr_is_data; // write hits a data register
  logic launch;
  logic [15:0] next_rdata;
  logic pol; // read-back polarity
  logic [3:0] w_req, r_req; // requested counts before clamping

  // link-domain signals seen here only through the handshake
  omc_res_t res; // stable from done toggle to next launch
  logic done_tgl;

  // pins from outside pass two flops before use
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      atten_s1 <= '0;
      atten_s2 <= '0;
      err_s1 <= '0;
      err_s2 <= '0;
    end else begin
      atten_s1 <= MOD_ATTEN_I;
      atten_s2 <= atten_s1;
      err_s1 <= MOD_ERR_I;
      err_s2 <= err_s1;
    end
  end

  // done toggle crossing; only the second and third flop are compared
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end
  assign done_ev = done_s2 ^ done_s3;

  // write decode of the per-module data registers
  // base plus offset
  always_comb begin
    wr_is_data = 1'b1;
    wr_mod = 2'd0;
    case (REG_ADDR_I)
      MODULE_BASE + OFS_DATA1: wr_mod = 2'd0;
      MODULE_BASE + OFS_DATA2: wr_mod = 2'd1;
      MODULE_BASE + OFS_DATA3: wr_mod = 2'd2;
      MODULE_BASE + OFS_DATA4: wr_mod = 2'd3;
      default: wr_is_data = 1'b0;
    endcase
  end

  // attenuator data write starts transfer
  // launches while busy are dropped, though the data word is still stored: the request bundle must stay stable
  assign launch = REG_WR_I && wr_is_data && atten_s2[wr_mod] && !busy;

  // prism switch register
  // one bit per path
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      prism <= '0;
    end else if (REG_WR_I && REG_ADDR_I == MODULE_BASE + OFS_PRISM) begin
      prism <= REG_WDATA_I[PRISM_BITS-1:0];
    end
  end

  // per-module data words; kept in both modes
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      mod_data <= '0;
    end else if (REG_WR_I && wr_is_data) begin
      mod_data[wr_mod] <= REG_WDATA_I;
    end
  end

  // control, command and target address registers
  // address register ignores its upper nine bits
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= '0;
      cmd_reg <= '0;
      tgt_addr <= DEFAULT_ADDR;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == MODULE_BASE + OFS_CTRL) begin
        ctrl <= REG_WDATA_I & CTRL_MASK;
      end
      if (REG_ADDR_I == MODULE_BASE + OFS_CMD) begin
        cmd_reg <= REG_WDATA_I;
      end
      if (REG_ADDR_I == MODULE_BASE + OFS_ADDR) begin
        tgt_addr <= REG_WDATA_I[6:0];
      end
    end
  end

  // count fields from the command register
  assign r_req = cmd_reg[CMD_R_LSB +: 4];
  assign w_req = cmd_reg[CMD_W_LSB +: 4];

  // launch: freeze the request and toggle it across
  // address, command, counts, data
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      req <= '0;
      req_tgl <= 1'b0;
      busy <= 1'b0;
    end else if (launch) begin
      req.mod <= wr_mod;
      req.addr <= tgt_addr;
      req.cmd <= cmd_reg[7:0];
      req.wcnt <= (w_req > CNT_MAX) ? CNT_MAX : w_req;
      req.rcnt <= (r_req > CNT_MAX) ? CNT_MAX : r_req;
      req.data <= REG_WDATA_I;
      req_tgl <= ~req_tgl;
      busy <= 1'b1;
    end else if (done_ev) begin
      busy <= 1'b0;
    end
  end

  // read-back words and link error flags
  // launch clears read-back
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      readback <= '0;
      comm_err <= '0;
    end else if (launch) begin
      readback <= '0;
      comm_err[wr_mod] <= 1'b0;
    end else if (done_ev) begin
      readback <= res.rx;
      comm_err[req.mod] <= res.nack;
    end
  end

  // read mux; unmapped and write-only locations read as all ones
  // area decode
  assign pol = ctrl[CTRL_POL_BIT];
  always_comb begin
    next_rdata = READ_UNMAPPED;
    if (REG_ADDR_I[9:8] == AREA_DATA) begin
      case (REG_ADDR_I)
        MODULE_BASE + OFS_PRISM:
          next_rdata = {PRISM_UNUSED, prism ^ {PRISM_BITS{pol}}};
        MODULE_BASE + OFS_DATA1,
        MODULE_BASE + OFS_DATA2,
        MODULE_BASE + OFS_DATA3,
        MODULE_BASE + OFS_DATA4: begin
          if (!atten_s2[wr_mod]) begin
            next_rdata = mod_data[wr_mod] ^ {16{pol}};
          end
        end
        MODULE_BASE + OFS_RB_FIRST: next_rdata = readback[31:16];
        MODULE_BASE + OFS_RB_LAST: next_rdata = readback[15:0];
        default: next_rdata = READ_UNMAPPED;
      endcase
    end else if (REG_ADDR_I[9:8] == AREA_CTRL) begin
      case (REG_ADDR_I)
        MODULE_BASE + OFS_CTRL: next_rdata = ctrl;
        MODULE_BASE + OFS_STAT:
          next_rdata = {HW_REV, 5'h00, comm_err, err_s2};
        default: next_rdata = READ_UNMAPPED;
      endcase
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= '0;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  // parallel outputs from flops
  // five channel bits to the port
  // reset bits pass straight out so the host can park a module
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      PRISM_CLOSE_O <= '0;
      CHAN_SEL_O <= '0;
      CHAN_RESET_O <= '0;
    end else begin
      PRISM_CLOSE_O <= prism;
      for (int i = 0; i < N_MOD; i++) begin
        CHAN_SEL_O[i] <= mod_data[i][CHAN_BITS-1:0];
      end
      CHAN_RESET_O <= ctrl[CTRL_RST_LSB +: N_MOD];
    end
  end

  // ---------------- link domain ----------------
  logic lrst_a, lrst; // reset released in step with the link clock
  logic req_s1, req_s2, req_s3; // request toggle synchroniser
  logic [N_MOD-1:0] sda_s1, sda_s2; // data line synchroniser
  omc_lstate_t lst;
  omc_req_t lreq; // captured request
  logic [4:0] qcnt; // cycles within a quarter bit
  logic qtick;
  logic [1:0] phase; // quarter of the current bit or condition
  logic [3:0] bitn; // 0..7 data bits, 8 acknowledge
  logic [7:0] sh; // shift register out and in
  logic [3:0] wleft, rleft; // bytes still to send and receive
  logic [2:0] txi; // index of byte being sent
  logic [2:0] rxn; // bytes received so far
  logic rd_phase, hdr; // read half, read address byte
  logic ack_hi; // acknowledge bit sampled high
  logic sda_in;
  logic scl_low, sda_low; // wanted line drive
  logic [7:0] tx_byte;

  // reset assert is immediate, release waits for two link edges
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lrst_a <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_a <= 1'b0;
      lrst <= lrst_a;
    end
  end

  // request toggle and data line synchronisers
  always_ff @(posedge LINK_CLK_I or posedge lrst) begin
    if (lrst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      sda_s1 <= '1;
      sda_s2 <= '1;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
    end
  end
  assign sda_in = sda_s2[lreq.mod];

  // quarter-bit timer, runs only inside a frame
  always_ff @(posedge LINK_CLK_I or posedge lrst) begin
    if (lrst) begin
      qcnt <= '0;
    end else if (lst == L_IDLE || lst == L_DONE || qtick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 5'd1;
    end
  end
  assign qtick = (qcnt == QTR_CYC - 5'd1);

  // bytes of the write half
  always_comb begin
    case (txi)
      3'd0: tx_byte = {lreq.addr, 1'b0};
      3'd1: tx_byte = lreq.cmd;
      3'd2: tx_byte = lreq.data[15:8];
      3'd3: tx_byte = lreq.data[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

  // frame sequencer
  // start, address, acks, stop
  always_ff @(posedge LINK_CLK_I or posedge lrst) begin
    if (lrst) begin
      lst <= L_IDLE;
      lreq <= '0;
      phase <= '0;
      bitn <= '0;
      sh <= '1;
      wleft <= '0;
      rleft <= '0;
      txi <= '0;
      rxn <= '0;
      rd_phase <= 1'b0;
      hdr <= 1'b0;
      ack_hi <= 1'b0;
      res <= '0;
      done_tgl <= 1'b0;
    end else begin
      case (lst)
        L_IDLE: begin
          if (req_s2 ^ req_s3) begin
            lreq <= req;
            wleft <= req.wcnt;
            rleft <= (req.rcnt == 4'd0) ? 4'd0 : req.rcnt - 4'd1;
            rd_phase <= (req.wcnt == 4'd0);
            txi <= '0;
            rxn <= '0;
            phase <= '0;
            res <= '0;
            // nothing to send or fetch closes the request at once
            if (req.wcnt == 4'd0 && req.rcnt <= 4'd1) begin
              lst <= L_DONE;
            end else begin
              lst <= L_START;
            end
          end
        end
        L_START: begin
          if (qtick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd3) begin
              bitn <= '0;
              hdr <= rd_phase;
              sh <= rd_phase ? {lreq.addr, 1'b1} : tx_byte;
              lst <= L_BIT;
            end
          end
        end
        L_BIT: begin
          if (qtick) begin
            phase <= phase + 2'd1;
            // sample while the clock is high
            if (phase == 2'd1) begin
              if (bitn == 4'd8) begin
                ack_hi <= sda_in;
              end else begin
                sh <= {sh[6:0], sda_in};
              end
            end
            if (phase == 2'd3) begin
              bitn <= bitn + 4'd1;
              if (bitn == 4'd8) begin
                bitn <= '0;
                if (!rd_phase || hdr) begin
                  // sent byte: no acknowledge ends the frame
                  if (ack_hi) begin
                    res.nack <= 1'b1;
                    lst <= L_STOP;
                  end else if (hdr) begin
                    hdr <= 1'b0;
                    sh <= '1;
                  end else if (wleft > 4'd1) begin
                    wleft <= wleft - 4'd1;
                    txi <= txi + 3'd1;
                    sh <= (txi == 3'd0) ? lreq.cmd
                        : (txi == 3'd1) ? lreq.data[15:8]
                        : (txi == 3'd2) ? lreq.data[7:0] : 8'h00;
                  end else if (rleft != 4'd0) begin
                    rd_phase <= 1'b1;
                    lst <= L_START;
                  end else begin
                    lst <= L_STOP;
                  end
                end else begin
                  // received byte; only four fit the read-back words
                  case (rxn)
                    3'd0: res.rx[31:24] <= sh;
                    3'd1: res.rx[23:16] <= sh;
                    3'd2: res.rx[15:8] <= sh;
                    3'd3: res.rx[7:0] <= sh;
                    default: res.rx <= res.rx;
                  endcase
                  rxn <= rxn + 3'd1;
                  rleft <= rleft - 4'd1;
                  sh <= '1;
                  if (rleft == 4'd1) begin
                    lst <= L_STOP;
                  end
                end
              end
            end
          end
        end
        L_STOP: begin
          if (qtick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd3) begin
              lst <= L_DONE;
            end
          end
        end
        L_DONE: begin
          // result is held until the next request is captured
          done_tgl <= ~done_tgl;
          lst <= L_IDLE;
        end
        default: lst <= L_IDLE;
      endcase
    end
  end

  // wanted line levels per state and quarter
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (lst)
      L_START: begin
        scl_low = (phase == 2'd0) || (phase == 2'd3);
        sda_low = phase[1];
      end
      L_BIT: begin
        scl_low = (phase == 2'd0) || (phase == 2'd3);
        if (bitn == 4'd8) begin
          // acknowledge received bytes except the last
          sda_low = rd_phase && !hdr && (rleft > 4'd1);
        end else if (rd_phase && !hdr) begin
          // the target owns the data line while it returns a byte
          sda_low = 1'b0;
        end else begin
          // the mid-bit sample shifts the sent bit into the low end;
          // following it there keeps data still while the clock is high
          sda_low = phase[1] ? ~sh[0] : ~sh[7];
        end
      end
      L_STOP: begin
        scl_low = (phase == 2'd0);
        sda_low = !phase[1];
      end
      default: begin
        scl_low = 1'b0;
        sda_low = 1'b0;
      end
    endcase
  end

  // separate bus per module
  // only the selected bus is ever pulled; the others stay released
  for (genvar g = 0; g < N_MOD; g++) begin : g_bus
    always_ff @(posedge LINK_CLK_I or posedge lrst) begin
      if (lrst) begin
        SCL_OE_O[g] <= 1'b0;
        SDA_OE_O[g] <= 1'b0;
      end else begin
        SCL_OE_O[g] <= scl_low && (lreq.mod == 2'(g));
        SDA_OE_O[g] <= sda_low && (lreq.mod == 2'(g));
      end
    end
    assign SCL_O[g] = 1'b0;
    assign SDA_O[g] = 1'b0;
  end

endmodule // omc_port_ctrl

// ==== sim/omc_port_ctrl_sva.sv ====
`timescale 1ns/1ps
module omc_port_ctrl_sva
  import omc_pkg::*;
(
  // system side
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [9:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic [N_MOD-1:0] MOD_ATTEN_I,
  input wire logic [PRISM_BITS-1:0] PRISM_CLOSE_O,
  input wire logic [N_MOD-1:0][CHAN_BITS-1:0] CHAN_SEL_O,
  input wire logic [N_MOD-1:0] CHAN_RESET_O,
  // link side
  input wire logic LINK_CLK_I,
  input wire logic [N_MOD-1:0] SCL_OE_O
);
  // two clock domains are watched, so every property names its clock
  a_rd_answer: assert property (
    @(posedge CLOCK_I) disable iff (RST_I) REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (
    @(posedge CLOCK_I) disable iff (RST_I) REG_RVALID_O |-> $past(REG_RD_I))
    else $error("answer without a read");
  a_prism_write: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == OFS_PRISM
    |-> ##2 PRISM_CLOSE_O == $past(REG_WDATA_I[11:0], 2))
    else $error("prism paths differ from written bits");
  a_prism_upper: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == OFS_PRISM |=> REG_RDATA_O[15:12] == 4'hf)
    else $error("prism upper nibble not ones");
  a_unused_area: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I[9] |=> REG_RDATA_O == READ_UNMAPPED)
    else $error("unused area read not all ones");
  a_addr_wo_read: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == OFS_ADDR |=> REG_RDATA_O == READ_UNMAPPED)
    else $error("address register readable");
  a_chan_port: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == OFS_DATA4 && !MOD_ATTEN_I[3]
    |-> ##2 CHAN_SEL_O[3] == $past(REG_WDATA_I[4:0], 2))
    else $error("channel port differs from data bits");
  a_chan_reset: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == OFS_CTRL
    |-> ##2 CHAN_RESET_O == $past(REG_WDATA_I[15:12], 2))
    else $error("reset pins differ from control bits");
  a_rdata_hold: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !REG_RVALID_O |-> $stable(REG_RDATA_O))
    else $error("read data moved without a read");
  // a clock low phase lasts at least eight link clock cycles
  a_scl_low_hold: assert property (
    @(posedge LINK_CLK_I) disable iff (RST_I)
    $rose(SCL_OE_O[0]) |-> SCL_OE_O[0] [*8])
    else $error("serial clock low phase too short");
endmodule // omc_port_ctrl_sva

bind omc_port_ctrl omc_port_ctrl_sva sva_u (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .MOD_ATTEN_I(MOD_ATTEN_I), .PRISM_CLOSE_O(PRISM_CLOSE_O),
  .CHAN_SEL_O(CHAN_SEL_O), .CHAN_RESET_O(CHAN_RESET_O),
  .LINK_CLK_I(LINK_CLK_I), .SCL_OE_O(SCL_OE_O)
);

// ==== sim/omc_atten_model.sv ====
`timescale 1ns/1ps
// behavioural attenuator on one serial bus
module omc_atten_model (
  // resolved bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  // behaviour controls
  input wire logic nack_i,
  input wire logic [7:0] seed_i,
  // pull-down and log of bytes taken
  output logic sda_oe_o,
  output logic [31:0] got_o
);
  int bitn = 0; // bit slot in the byte
  int k = 0; // index of returned byte
  logic [7:0] sh = '0; // receive shifter
  logic [7:0] dat = '0; // byte being returned
  logic rd = 1'b0; // master reads
  logic go = 1'b0; // keep returning bytes
  logic first = 1'b0; // next byte is the address
  logic mack = 1'b0; // master acked last byte
  initial begin
    sda_oe_o = 1'b0;
    got_o = '0;
  end
  always @(negedge sda_i) begin
    if (scl_i) begin
      bitn = -1;
      first = 1'b1;
      rd = 1'b0;
      go = 1'b0;
      k = 0;
    end
  end
  // sample while the clock is high
  always @(posedge scl_i) begin
    if (!rd && bitn < 8) sh = {sh[6:0], sda_i};
    else if (rd && bitn == 8) mack = !sda_i;
  end
  // our pull changes only with the clock low
  always @(negedge scl_i) begin
    bitn++;
    if (bitn == 8 && !rd) begin
      got_o = {got_o[23:0], sh};
      sda_oe_o = !nack_i;
    end else if (bitn == 8) begin
      sda_oe_o = 1'b0;
    end else if (bitn == 9) begin
      bitn = 0;
      if (first) rd = sh[0];
      go = rd && (first || mack);
      first = 1'b0;
      dat = seed_i + 8'(k);
      k++;
      sda_oe_o = go && !dat[7];
    end else if (go && bitn > 0) begin
      sda_oe_o = !dat[7-bitn];
    end
  end
endmodule // omc_atten_model

// ==== sim/optical_module_port_controller_tb.sv ====
`timescale 1ns/1ps
module optical_module_port_controller_tb;
  import omc_pkg::*;
  // clocks and register port
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] wdat = '0;
  logic [15:0] rdat;
  logic rval;
  // positions one to three attenuators, four a multi-switch
  logic [3:0] atten = 4'h7;
  logic [3:0] merr = '0;
  logic [3:0] nack = 4'h2; // bus two refuses every byte
  logic [3:0][7:0] seed = '0;
  logic [11:0] prism;
  logic [3:0][4:0] chan;
  logic [3:0] chrst, scl_oe, sda_oe, sda, p_oe;
  logic [3:0][31:0] got;
  int failures = 0;
  int checks = 0;
  logic [15:0] v;
  logic [7:0] c;
  logic [7:0] q[$]; // expected read-back bytes
  always #5 clk = ~clk;
  always #62.5 lclk = ~lclk;
  // open-drain data lines with pull-ups
  assign sda = ~(sda_oe | p_oe);
  omc_port_ctrl dut_u (
    .CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr_s),
    .REG_RD_I(rd_s), .REG_WDATA_I(wdat), .REG_RDATA_O(rdat),
    .REG_RVALID_O(rval), .MOD_ATTEN_I(atten), .MOD_ERR_I(merr),
    .PRISM_CLOSE_O(prism), .CHAN_SEL_O(chan), .CHAN_RESET_O(chrst),
    .LINK_CLK_I(lclk), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda),
    .SDA_O(), .SDA_OE_O(sda_oe));
  for (genvar i = 0; i < 4; i++) begin : g_mod
    omc_atten_model pu (.scl_i(~scl_oe[i]), .sda_i(sda[i]),
      .nack_i(nack[i]), .seed_i(seed[i]), .sda_oe_o(p_oe[i]),
      .got_o(got[i]));
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(32'({rval, rdat}), 32'({1'b1, e}));
  endtask
  // wait until the bus has stayed idle for 1000 cycles
  task automatic frame(input int b);
    int n;
    int t;
    n = 0;
    t = 0;
    while (n < 1000 && t < 60000) begin
      @(posedge clk);
      t++;
      n = (scl_oe[b] | sda_oe[b]) ? 0 : n + 1;
    end
    chk(32'(t < 60000), 32'h1);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the three frames take about 830 us in all
  initial begin
    #950000;
    failures++;
    stop_test();
  end
  initial begin
    void'($urandom(32'he3d8));
    repeat (6) @(posedge clk);
    merr <= 4'($urandom);
    seed[2] <= 8'($urandom);
    @(posedge lclk);
    @(posedge lclk);
    @(posedge clk);
    rst <= 1'b0;
    rd(OFS_PRISM, 16'hf000);
    rd(OFS_DATA4, 16'h0000);
    rd(OFS_DATA1, READ_UNMAPPED);
    rd(OFS_ADDR, READ_UNMAPPED);
    rd(10'h200, READ_UNMAPPED);
    rd(10'h003, READ_UNMAPPED);
    wr(OFS_RB_LAST, 16'($urandom));
    rd(OFS_RB_LAST, 16'h0000);
    $display("map test done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0fff : (i == 1) ? 16'hfffe : 16'($urandom);
      wr(OFS_PRISM, v);
      rd(OFS_PRISM, {PRISM_UNUSED, v[11:0]});
      chk(32'(prism), 32'(v[11:0]));
    end
    $display("prism test done");
    // channel n written as n minus one, all 32 channels
    for (int i = 1; i <= 32; i++) begin
      v = 16'(i - 1);
      wr(OFS_DATA4, v);
      rd(OFS_DATA4, v);
      chk(32'(chan[3]), 32'(v[4:0]));
    end
    v = 16'($urandom) & 16'hfdff;
    wr(OFS_CTRL, v);
    rd(OFS_CTRL, v & CTRL_MASK);
    chk(32'(chrst), 32'(v[15:12]));
    wr(OFS_CTRL, 16'h8000);
    wr(OFS_DATA4, 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    rd(OFS_CTRL, 16'h0000);
    chk(32'({chrst, chan[3]}), 32'h0);
    $display("switch test done");
    // default address kept, command, then launch
    wr(OFS_CMD, 16'h0230);
    wr(OFS_DATA2, 16'h1234);
    frame(1);
    chk(got[1][7:0], 32'h92);
    c = 8'($urandom);
    wr(OFS_CMD, {8'h02, c});
    wr(OFS_DATA1, 16'($urandom));
    frame(0);
    chk(got[0][15:0], {16'h0, 8'h92, c});
    rd(OFS_STAT, {HW_REV, 5'h0, 4'h2, merr});
    // query on bus three with a loaded address
    v = 16'($urandom);
    c = 8'($urandom);
    q = {seed[2], 8'(seed[2] + 8'h01), 8'h00, 8'h00};
    wr(OFS_ADDR, v);
    wr(OFS_CMD, {8'h32, c});
    wr(OFS_DATA3, 16'h0000);
    frame(2);
    chk(got[2][23:0], {8'h0, v[6:0], 1'b0, c, v[6:0], 1'b1});
    rd(OFS_RB_FIRST, {q[0], q[1]});
    rd(OFS_RB_LAST, {q[2], q[3]});
    // a launch with nothing to send still clears read-back
    wr(OFS_CMD, 16'h0000);
    wr(OFS_DATA1, 16'h0000);
    // read before the empty result can cross back
    rd(OFS_RB_FIRST, 16'h0000);
    repeat (100) @(posedge clk);
    rd(OFS_RB_FIRST, 16'h0000);
    $display("serial test done");
    stop_test();
  end
endmodule // optical_module_port_controller_tb
